// [servo_special_settings_status.sv]
// Purpose: Node address display timer, torque limit output selection,
//          profile software limits, home offset and power-off warning
// Assumes: 25 MHz core_clk, external pins pass a three-stage synchroniser
// Notes on behaviour
// - Display time counts in 100 ms steps, setting range -1 to 1000.
// - Settings 0 through 6 show the address for a fixed 600 ms.
// - Setting -1 shows address until link and servo sync are both up.
// - Selector 0: output on for any torque limiting, command included.
// - Selector 1: output only for limiting not caused by torque command.
// - 2-bit enable: 0 both, 1 no positive, 2 no negative, 3 none.
// - Flag goes to 1 when position passes the matching soft limit.
// - A disabled limit reports its flag as 0.
// - Both flags read 0 until homing has completed.
// - Limits are signed 32-bit within plus or minus 1073741823.
// - Signed home offset added to absolute position gives mechanical position.
// - Power-lost flag sets after main power off for the warning time.
// - Warning time 0 to 9 or 2000 disables the power-off warning.
// - Times 10 to 1999 in 1 ms, counted at 2 ms resolution.
// - Undervoltage error raised first wins over a later power-off warning.
`timescale 1ns/100ps
`include "servo_special_params.svh"
module servo_special_settings_status #(
	parameter int CYC_PER_MS = `CYC_PER_MS
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [4:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	// Drive status pins (asynchronous)
	input  wire logic        linkUp,
	input  wire logic        servoSync,
	input  wire logic        mainPowerOff,
	input  wire logic        mainUndervolt,
	// Same-clock drive logic
	input  wire logic        torqueLimited,
	input  wire logic        torqueCmdLimited,
	input  wire logic        profilePosition,
	input  wire logic        homeDone,
	input  wire logic [31:0] cmdPosition,
	input  wire logic [31:0] absPosition,
	// Outputs
	output logic             showAddress,
	output logic             torqueLimitOut,
	output logic             posSoftLimitFlag,
	output logic             negSoftLimitFlag,
	output logic             mainPowerLostFlag,
	output logic             mainUndervoltError,
	output logic      [31:0] mechPosition,
	output logic             irq
);
	// Settings registers
	logic [15:0] dispTime_q;
	logic        tqSel_q;
	logic [15:0] rsvdF_q;
	logic [1:0]  slEn_q;
	logic [31:0] slPos_q;
	logic [31:0] slNeg_q;
	logic [31:0] homeOfs_q;
	logic [15:0] warnTime_q;
	logic [3:0]  irqStat_q;
	logic [3:0]  irqMask_q;

	// Pin synchronisers, three stages each
	logic [2:0] linkSync_q, servoSync_q, pwrSync_q, uvSync_q;
	logic       linkOk_q, servoOk_q, pwrOff_q, uv_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			linkSync_q  <= 3'h0;
			servoSync_q <= 3'h0;
			pwrSync_q   <= 3'h0;
			uvSync_q    <= 3'h0;
		end else begin
			linkSync_q  <= {linkSync_q[1:0], linkUp};
			servoSync_q <= {servoSync_q[1:0], servoSync};
			pwrSync_q   <= {pwrSync_q[1:0], mainPowerOff};
			uvSync_q    <= {uvSync_q[1:0], mainUndervolt};
		end
	end

	// Settled levels change once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			linkOk_q  <= 1'b0;
			servoOk_q <= 1'b0;
			pwrOff_q  <= 1'b0;
			uv_q      <= 1'b0;
		end else begin
			if (linkSync_q[1] == linkSync_q[2]) linkOk_q <= linkSync_q[2];
			if (servoSync_q[1] == servoSync_q[2]) servoOk_q <= servoSync_q[2];
			if (pwrSync_q[1] == pwrSync_q[2]) pwrOff_q <= pwrSync_q[2];
			if (uvSync_q[1] == uvSync_q[2]) uv_q <= uvSync_q[2];
		end
	end

	// Millisecond tick
	logic msTick;
	ms_tick_gen #(
		.CYCLES (CYC_PER_MS)
	) u_tick (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (msTick)
	);

	// Register write decode
	wire wrDisp  = regWr && regAddr == `ADDR_DISP_TIME;
	wire wrTq    = regWr && regAddr == `ADDR_TQ_SEL;
	wire wrRsvdF = regWr && regAddr == `ADDR_RSVD_F;
	wire wrSlEn  = regWr && regAddr == `ADDR_SL_EN;
	wire wrSlPos = regWr && regAddr == `ADDR_SL_POS;
	wire wrSlNeg = regWr && regAddr == `ADDR_SL_NEG;
	wire wrHome  = regWr && regAddr == `ADDR_HOME_OFS;
	wire wrWarn  = regWr && regAddr == `ADDR_WARN_TIME;
	wire wrStat  = regWr && regAddr == `ADDR_IRQ_STAT;
	wire wrMask  = regWr && regAddr == `ADDR_IRQ_MASK;

	// Clamp a limit or offset into the signed 30-bit magnitude range
	function automatic logic [31:0] clampLim(input logic [31:0] v);
		if ($signed(v) > $signed(`LIMIT_MAG)) clampLim = `LIMIT_MAG;
		else if ($signed(v) < -$signed(`LIMIT_MAG)) clampLim = -`LIMIT_MAG;
		else clampLim = v;
	endfunction

	// Settings storage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dispTime_q <= `RST_DISP_TIME;
			tqSel_q    <= 1'b0;
			rsvdF_q    <= `RST_RSVD_F;
			slEn_q     <= 2'h0;
			slPos_q    <= 32'h0;
			slNeg_q    <= 32'h0;
			homeOfs_q  <= 32'h0;
			warnTime_q <= `RST_WARN_TIME;
			irqMask_q  <= 4'h0;
		end else begin
			if (wrDisp) dispTime_q <= regWdata[15:0];
			if (wrTq) tqSel_q <= regWdata[0];
			if (wrRsvdF) rsvdF_q <= regWdata[15:0];
			if (wrSlEn) slEn_q <= regWdata[1:0];
			if (wrSlPos) slPos_q <= clampLim(regWdata);
			if (wrSlNeg) slNeg_q <= clampLim(regWdata);
			if (wrHome) homeOfs_q <= clampLim(regWdata);
			if (wrWarn) warnTime_q <= regWdata[15:0];
			if (wrMask) irqMask_q <= regWdata[3:0];
		end
	end

	// Address display timer
	servo_special_pkg::disp_state_t dispSt_q;
	logic [15:0] dispSteps_q;
	logic [6:0]  msInStep_q;
	wire         dispForever = dispTime_q == 16'hffff;
	wire         dispShort   = !dispTime_q[15] && dispTime_q <= 16'd6;
	wire [15:0]  dispTarget  = dispShort ? 16'(`DISP_MIN_STEPS) : dispTime_q;
	wire         stepTick    = msTick && msInStep_q == 7'(`DISP_STEP_MS - 1);
	wire         dispEnd     = dispForever ? (linkOk_q && servoOk_q)
		: (stepTick && dispSteps_q + 16'h1 >= dispTarget);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dispSt_q    <= servo_special_pkg::DISP_SHOW;
			dispSteps_q <= 16'h0;
			msInStep_q  <= 7'h0;
		end else begin
			unique case (dispSt_q)
				servo_special_pkg::DISP_SHOW: begin
					dispSt_q <= servo_special_pkg::DISP_WAIT;
				end
				servo_special_pkg::DISP_WAIT: begin
					if (msTick) msInStep_q <= stepTick ? 7'h0 : msInStep_q + 7'h1;
					if (stepTick) dispSteps_q <= dispSteps_q + 16'h1;
					if (dispEnd) dispSt_q <= servo_special_pkg::DISP_DONE;
				end
				servo_special_pkg::DISP_DONE: begin
					dispSt_q <= servo_special_pkg::DISP_DONE;
				end
				default: dispSt_q <= servo_special_pkg::DISP_DONE;
			endcase
		end
	end
	wire dispEvent = dispSt_q == servo_special_pkg::DISP_WAIT && dispEnd;

	// Torque limit output selection
	wire tqOut = tqSel_q ? (torqueLimited && !torqueCmdLimited)
		: torqueLimited;

	// Software limit comparison
	wire posEn  = !slEn_q[0];
	wire negEn  = !slEn_q[1];
	wire posHit = profilePosition && homeDone && posEn
		&& $signed(cmdPosition) > $signed(slPos_q);
	wire negHit = profilePosition && homeDone && negEn
		&& $signed(cmdPosition) < $signed(slNeg_q);

	// Power-off warning timer, 2 ms resolution
	logic [15:0] offMs_q;
	logic        msOdd_q;
	wire warnEn  = warnTime_q >= `WARN_MIN && warnTime_q < `WARN_OFF;
	wire warnHit = warnEn && pwrOff_q && !uv_q
		&& offMs_q >= {warnTime_q[15:1], 1'b0};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			offMs_q <= 16'h0;
			msOdd_q <= 1'b0;
		end else if (!pwrOff_q) begin
			offMs_q <= 16'h0;
			msOdd_q <= 1'b0;
		end else if (msTick) begin
			msOdd_q <= !msOdd_q;
			if (msOdd_q && offMs_q != 16'hfffe) offMs_q <= offMs_q + 16'h2;
		end
	end

	// Output flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			showAddress        <= 1'b1;
			torqueLimitOut     <= 1'b0;
			posSoftLimitFlag   <= 1'b0;
			negSoftLimitFlag   <= 1'b0;
			mainPowerLostFlag  <= 1'b0;
			mainUndervoltError <= 1'b0;
			mechPosition       <= 32'h0;
		end else begin
			showAddress        <= dispSt_q != servo_special_pkg::DISP_DONE && !dispEvent;
			torqueLimitOut     <= tqOut;
			posSoftLimitFlag   <= posHit;
			negSoftLimitFlag   <= negHit;
			mainPowerLostFlag  <= warnHit;
			mainUndervoltError <= uv_q && !mainPowerLostFlag;
			mechPosition       <= absPosition + homeOffs();
		end
	end

	function automatic logic [31:0] homeOffs();
		homeOffs = homeOfs_q;
	endfunction

	// Sticky status, set wins over write-one-to-clear
	wire [3:0] evt;
	assign evt[`BIT_POS_SL]    = posHit;
	assign evt[`BIT_NEG_SL]    = negHit;
	assign evt[`BIT_PWR_LOST]  = warnHit;
	assign evt[`BIT_DISP_DONE] = dispEvent;
	wire [3:0] statClr = wrStat ? regWdata[3:0] : 4'h0;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_q <= 4'h0;
			irq       <= 1'b0;
		end else begin
			irqStat_q <= (irqStat_q & ~statClr) | evt;
			irq       <= |(((irqStat_q & ~statClr) | evt) & irqMask_q);
		end
	end

	// Read mux
	wire [3:0] liveFlags = {!showAddress, mainPowerLostFlag, negSoftLimitFlag,
		posSoftLimitFlag};
	wire inRsvd = regAddr >= `ADDR_RSVD_A && regAddr < `ADDR_RSVD_F;
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0;
		unique case (1'b1)
			regAddr == `ADDR_DISP_TIME: rdMux = {{16{dispTime_q[15]}}, dispTime_q};
			regAddr == `ADDR_TQ_SEL:    rdMux = {31'h0, tqSel_q};
			regAddr == `ADDR_RSVD_F:    rdMux = {16'h0, rsvdF_q};
			regAddr == `ADDR_SL_EN:     rdMux = {30'h0, slEn_q};
			regAddr == `ADDR_SL_POS:    rdMux = slPos_q;
			regAddr == `ADDR_SL_NEG:    rdMux = slNeg_q;
			regAddr == `ADDR_HOME_OFS:  rdMux = homeOfs_q;
			regAddr == `ADDR_WARN_TIME: rdMux = {16'h0, warnTime_q};
			regAddr == `ADDR_IRQ_STAT:  rdMux = {28'h0, irqStat_q};
			regAddr == `ADDR_IRQ_MASK:  rdMux = {28'h0, irqMask_q};
			regAddr == `ADDR_FLAGS:     rdMux = {28'h0, liveFlags};
			regAddr == `ADDR_MECH_POS:  rdMux = mechPosition;
			inRsvd:                     rdMux = 32'h0;
			default:                    rdMux = 32'h0;
		endcase
	end

	// Read data one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) regRdata <= 32'h0;
		else regRdata <= regRd ? rdMux : 32'h0;
	end

	// Checks
	chk_tq_sel1: assert property (@(posedge core_clk) disable iff (!rst_n)
		tqSel_q && torqueCmdLimited |=> !torqueLimitOut)
		else $error("torque output on for command limiting");
	chk_tq_sel0: assert property (@(posedge core_clk) disable iff (!rst_n)
		!tqSel_q && torqueLimited |=> torqueLimitOut)
		else $error("torque output missing");
	chk_home_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		!homeDone |=> !posSoftLimitFlag && !negSoftLimitFlag)
		else $error("limit flag before homing");
	chk_pos_dis: assert property (@(posedge core_clk) disable iff (!rst_n)
		slEn_q[0] |=> !posSoftLimitFlag)
		else $error("disabled positive flag set");
	chk_neg_dis: assert property (@(posedge core_clk) disable iff (!rst_n)
		slEn_q[1] |=> !negSoftLimitFlag)
		else $error("disabled negative flag set");
	chk_pos_hit: assert property (@(posedge core_clk) disable iff (!rst_n)
		profilePosition && homeDone && !slEn_q[0]
		&& $signed(cmdPosition) > $signed(slPos_q) |=> posSoftLimitFlag)
		else $error("positive limit not flagged");
	chk_warn_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(warnTime_q < 16'd10 || warnTime_q == 16'd2000) |=> !mainPowerLostFlag)
		else $error("warning while disabled");
	chk_warn_time: assert property (@(posedge core_clk) disable iff (!rst_n)
		mainPowerLostFlag |-> pwrOff_q || $past(pwrOff_q))
		else $error("warning without power off");
	chk_mech_pos: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> mechPosition == $past(absPosition) + $past(homeOfs_q))
		else $error("mechanical position wrong");
	chk_disp_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		dispForever && !(linkOk_q && servoOk_q) && dispSt_q != servo_special_pkg::DISP_DONE
		|=> showAddress)
		else $error("address display ended early");
	chk_disp_short: assert property (@(posedge core_clk) disable iff (!rst_n)
		dispShort && dispSt_q != servo_special_pkg::DISP_DONE
		&& dispSteps_q + 16'h1 < 16'(`DISP_MIN_STEPS) |=> showAddress)
		else $error("short address display ended early");
	chk_neg_hit: assert property (@(posedge core_clk) disable iff (!rst_n)
		profilePosition && homeDone && !slEn_q[1]
		&& $signed(cmdPosition) < $signed(slNeg_q) |=> negSoftLimitFlag)
		else $error("negative limit not flagged");
	chk_uv_first: assert property (@(posedge core_clk) disable iff (!rst_n)
		uv_q |=> !mainPowerLostFlag)
		else $error("warning raised during undervoltage");
	chk_stat_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n && evt != 4'h0 |=> (irqStat_q & $past(evt)) == $past(evt))
		else $error("status event lost");
	chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> irq == |(irqStat_q & $past(irqMask_q)))
		else $error("interrupt level wrong");
endmodule

// [servo_special_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz core clock, word-indexed register port
// Notes:   Definitions only
`ifndef SERVO_SPECIAL_PARAMS_SVH
`define SERVO_SPECIAL_PARAMS_SVH

// Register addresses (word index)
`define ADDR_DISP_TIME     5'h01
`define ADDR_TQ_SEL        5'h03
`define ADDR_RSVD_A        5'h04
`define ADDR_RSVD_F        5'h09
`define ADDR_SL_EN         5'h0a
`define ADDR_SL_POS        5'h0b
`define ADDR_SL_NEG        5'h0c
`define ADDR_HOME_OFS      5'h0d
`define ADDR_WARN_TIME     5'h0e
`define ADDR_IRQ_STAT      5'h10
`define ADDR_IRQ_MASK      5'h11
`define ADDR_FLAGS         5'h12
`define ADDR_MECH_POS      5'h13

// Reset values
`define RST_DISP_TIME      16'h0000
`define RST_RSVD_F         16'h0168
`define RST_WARN_TIME      16'h0000

// Status / flag bit positions
`define BIT_POS_SL         0
`define BIT_NEG_SL         1
`define BIT_PWR_LOST       2
`define BIT_DISP_DONE      3

// Timing
`define CLK_MHZ            25
`define DISP_STEP_MS       100
`define DISP_MIN_MS        600
`define WARN_RES_MS        2
`define CYC_PER_MS         (`CLK_MHZ * 1000)
`define DISP_MIN_STEPS     (`DISP_MIN_MS / `DISP_STEP_MS)
`define WARN_MIN           16'd10
`define WARN_OFF           16'd2000
`define LIMIT_MAG          32'h3fffffff

`endif

// [servo_special_pkg.sv]
// Purpose: Shared types for the special settings block
// Assumes: Nothing
// Notes:   Types only, constants live in the params header
package servo_special_pkg;
	typedef enum logic [1:0] {
		DISP_SHOW = 2'b00,
		DISP_WAIT = 2'b01,
		DISP_DONE = 2'b11
	} disp_state_t;
endpackage

// [ms_tick_gen.sv]
// Purpose: Millisecond tick generator
// Assumes: CYCLES cycles of core_clk per tick
// Notes:   Tick is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
module ms_tick_gen #(
	parameter int CYCLES = 25000
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Tick out
	output logic      tick
);
	logic [31:0] cnt_q;

	// Free running divider
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
			tick  <= 1'b0;
		end else if (cnt_q == 32'(CYCLES - 1)) begin
			cnt_q <= 32'h0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule

// [host_model.sv]
// Purpose: Host controller model driving the parameter register port
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Signals change by non-blocking assignment after a rising edge
`timescale 1ns/100ps
`include "servo_special_params.svh"
module host_model #(
	parameter int SHUTOFF_MS = 4000
) (
	// Clock
	input  wire logic        core_clk,
	// Register port
	output logic      [4:0]  regAddr,
	output logic      [31:0] regWdata,
	output logic             regWr,
	output logic             regRd,
	input  wire logic [31:0] regRdata
);
	// Idle bus at time zero
	initial begin
		regAddr = 5'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// One-cycle write, data scrambled afterwards
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
		regWdata <= ~d;
	endtask

	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask

	// Limit pair only written when positive stays above negative
	task automatic setLimits(input logic signed [31:0] p, input logic signed [31:0] n);
		if (p > n) begin
			wr(`ADDR_SL_NEG, n);
			wr(`ADDR_SL_POS, p);
		end
	endtask

	// Warning time kept below the shut-off detection time
	task automatic setWarn(input logic [15:0] t);
		if (t < SHUTOFF_MS) begin
			wr(`ADDR_WARN_TIME, {16'h0, t});
		end
	endtask
endmodule

// [tb_servo_special_settings_status.sv]
// Purpose: Self-checking bench for the special settings block
// Assumes: Millisecond shortened to 4 cycles
// Notes:   Register traffic goes through the host model tasks
`timescale 1ns/100ps
`include "servo_special_params.svh"
module tb_servo_special_settings_status;
	localparam int CPM = 4;
	// Inputs
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        linkUp = 1'b0;
	logic        servoSync = 1'b0;
	logic        mainPowerOff = 1'b0;
	logic        mainUndervolt = 1'b0;
	logic        torqueLimited = 1'b0;
	logic        torqueCmdLimited = 1'b0;
	logic        profilePosition = 1'b0;
	logic        homeDone = 1'b0;
	logic [31:0] cmdPosition = 32'h0;
	logic [31:0] absPosition = 32'h0;
	// Bus and outputs
	logic [4:0]  regAddr;
	logic [31:0] regWdata, regRdata, mechPosition, rdv;
	logic        regWr, regRd, showAddress, torqueLimitOut, irq;
	logic        posSoftLimitFlag, negSoftLimitFlag, mainPowerLostFlag, mainUndervoltError;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	servo_special_settings_status #(.CYC_PER_MS(CPM)) i_dut (
		.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.linkUp, .servoSync, .mainPowerOff, .mainUndervolt, .torqueLimited,
		.torqueCmdLimited, .profilePosition, .homeDone, .cmdPosition, .absPosition,
		.showAddress, .torqueLimitOut, .posSoftLimitFlag, .negSoftLimitFlag,
		.mainPowerLostFlag, .mainUndervoltError, .mechPosition, .irq
	);
	host_model i_host (.core_clk, .regAddr, .regWdata, .regWr, .regRd, .regRdata);

	// Clock
	initial begin
		forever #20 core_clk = ~core_clk;
	end

	// Hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Reset, set display time, watch the address display end
	task automatic dispTest(input logic [15:0] s, input int steps);
		linkUp <= 1'b0;
		servoSync <= 1'b0;
		rst_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		i_host.wr(`ADDR_DISP_TIME, {{16{s[15]}}, s});
		tick(steps * 100 * CPM - 20);
		check(showAddress, 1'b1);
		if (s == 16'hffff) begin
			@(posedge core_clk);
			linkUp <= 1'b1;
			servoSync <= 1'b1;
		end
		tick(40);
		check(showAddress, 1'b0);
		@(posedge core_clk);
		$display("display test %0d done", steps);
	endtask

	initial begin
		dispTest(16'h0000, 6);
		dispTest(16'h0007, 7);
		dispTest(16'hffff, 8);
		i_host.rd(`ADDR_DISP_TIME, rdv);
		check(rdv, 32'hffffffff);
		// Display-done event through mask and write-one-to-clear
		i_host.wr(`ADDR_IRQ_MASK, 32'h8);
		tick(2);
		check(irq, 1'b1);
		i_host.wr(`ADDR_IRQ_STAT, 32'h8);
		tick(2);
		check(irq, 1'b0);
		i_host.rd(`ADDR_RSVD_A, rdv);
		check(rdv, 32'h0);
		i_host.rd(`ADDR_RSVD_F, rdv);
		check(rdv, 32'h168);
		i_host.wr(5'h1f, 32'h1234);
		i_host.rd(5'h1f, rdv);
		check(rdv, 32'h0);
		$display("interrupt and register test done");
		// Torque output for both selectors, command-caused or not
		for (int k = 0; k < 4; k++) begin
			i_host.wr(`ADDR_TQ_SEL, {31'h0, k[1]});
			torqueLimited <= 1'b1;
			torqueCmdLimited <= k[0];
			tick(2);
			check(torqueLimitOut, !(k[1] && k[0]));
		end
		@(posedge core_clk);
		torqueLimited <= 1'b0;
		tick(2);
		check(torqueLimitOut, 1'b0);
		$display("torque test done");
		// Soft limits: homing gate, all enable codes, boundary
		i_host.setLimits(32'sd100, -32'sd100);
		profilePosition <= 1'b1;
		cmdPosition <= 32'd200;
		tick(2);
		check({posSoftLimitFlag, negSoftLimitFlag}, 2'b00);
		@(posedge core_clk);
		homeDone <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			i_host.wr(`ADDR_SL_EN, {30'h0, k[1:0]});
			cmdPosition <= k[2] ? -32'sd200 : 32'sd200;
			tick(2);
			check({posSoftLimitFlag, negSoftLimitFlag}, k[2] ? {1'b0, !k[1]} : {!k[0], 1'b0});
		end
		i_host.wr(`ADDR_SL_EN, 32'h0);
		cmdPosition <= 32'd100;
		tick(2);
		check({posSoftLimitFlag, negSoftLimitFlag}, 2'b00);
		i_host.wr(`ADDR_SL_POS, 32'h7fffffff);
		i_host.rd(`ADDR_SL_POS, rdv);
		check(rdv, 32'h3fffffff);
		i_host.wr(`ADDR_SL_NEG, 32'h80000000);
		i_host.rd(`ADDR_SL_NEG, rdv);
		check(rdv, 32'hc0000001);
		i_host.wr(`ADDR_HOME_OFS, -32'sd5);
		absPosition <= 32'd1000;
		tick(2);
		check(mechPosition, 32'd995);
		i_host.rd(`ADDR_MECH_POS, rdv);
		check(rdv, 32'd995);
		i_host.rd(`ADDR_FLAGS, rdv);
		check(rdv, 32'h8);
		i_host.rd(`ADDR_IRQ_STAT, rdv);
		check(rdv, 32'h3);
		$display("limit and offset test done");
		// Power-off warning: enabled, disabled codes, undervoltage first
		i_host.setWarn(16'd10);
		mainPowerOff <= 1'b1;
		tick(30);
		check(mainPowerLostFlag, 1'b0);
		tick(40);
		check(mainPowerLostFlag, 1'b1);
		@(posedge core_clk);
		mainPowerOff <= 1'b0;
		tick(10);
		for (int k = 0; k < 2; k++) begin
			i_host.setWarn(k == 0 ? 16'd9 : 16'd2000);
			mainPowerOff <= 1'b1;
			tick(100);
			check(mainPowerLostFlag, 1'b0);
			@(posedge core_clk);
			mainPowerOff <= 1'b0;
			tick(10);
		end
		i_host.setWarn(16'd10);
		mainUndervolt <= 1'b1;
		tick(10);
		@(posedge core_clk);
		mainPowerOff <= 1'b1;
		tick(80);
		check({mainUndervoltError, mainPowerLostFlag}, 2'b10);
		i_host.rd(`ADDR_IRQ_STAT, rdv);
		check(rdv, 32'h7);
		$display("power test done");
		wrap_up();
	end
endmodule
